/* File: core/prio_bank_pkg.sv */
package prio_bank_pkg;
	localparam int          REG_COUNT    = 6;
	localparam int          FIELD_COUNT  = 17;
	localparam int          FIELD_W      = 3;
	localparam int          ADDR_W       = 5;
	// Byte addresses of the priority registers
	localparam logic [4:0]  CTRL11_ADDR  = 5'h00;
	localparam logic [4:0]  CTRL12_ADDR  = 5'h04;
	localparam logic [4:0]  CTRL13_ADDR  = 5'h08;
	localparam logic [4:0]  CTRL14_ADDR  = 5'h0C;
	localparam logic [4:0]  CTRL15_ADDR  = 5'h10;
	localparam logic [4:0]  CTRL16_ADDR  = 5'h14;
	// Implemented-bit masks, one per register
	localparam logic [15:0] CTRL11_MASK  = 16'h7707;
	localparam logic [15:0] CTRL12_MASK  = 16'h7777;
	localparam logic [15:0] CTRL13_MASK  = 16'h7777;
	localparam logic [15:0] CTRL14_MASK  = 16'h7007;
	localparam logic [15:0] CTRL15_MASK  = 16'h0077;
	localparam logic [15:0] CTRL16_MASK  = 16'h0770;
	// Every field loads 100 (level 4) at reset
	localparam logic [15:0] PRIO_RESET   = 16'h4444;
	localparam logic [2:0]  PRIO_OFF     = 3'h0;
	localparam logic [2:0]  PRIO_LOWEST  = 3'h1;
	localparam logic [2:0]  PRIO_HIGHEST = 3'h7;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : prio_bank_pkg

/* File: core/prio_word_reg.sv */
`timescale 1ns/100ps
// One 16-bit priority word; only bits in MASK store anything
module prio_word_reg #(
	parameter logic [15:0] MASK = 16'hFFFF
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_strb,
	output logic      [15:0] value
);
	logic [15:0] value_reg;
	logic [15:0] value_next;
	logic [15:0] lane_mask;

	assign lane_mask  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & MASK;
	assign value_next = (value_reg & ~lane_mask) | (wr_data & lane_mask);
	assign value      = value_reg & MASK;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			value_reg <= prio_bank_pkg::PRIO_RESET & MASK;
		else if (wr_en)
			value_reg <= value_next;
	end

	prio_reset_a: assert property (@(posedge clk)
		$rose(resetn) |-> value == (prio_bank_pkg::PRIO_RESET & MASK))
		else $error("priority word not at reset value");
	unused_zero_a: assert property (@(posedge clk) disable iff (!resetn)
		(value & ~MASK) == 16'h0000)
		else $error("unimplemented bit reads nonzero");
	write_store_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_en && wr_strb == 2'h3 |=> value == ($past(wr_data) & MASK))
		else $error("written value not stored");
	hold_value_a: assert property (@(posedge clk) disable iff (!resetn)
		!wr_en |=> $stable(value))
		else $error("priority word changed without write");
endmodule : prio_word_reg

/* File: core/prio_level_decode.sv */
`timescale 1ns/100ps
// Turns a field code into a service level and an enable
module prio_level_decode (
	input  wire logic [2:0] code,
	output logic      [2:0] level,
	output logic            enabled
);
	assign enabled = code != prio_bank_pkg::PRIO_OFF;
	assign level   = code;
endmodule : prio_level_decode

/* File: core/interrupt_priority_bank.sv */
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module interrupt_priority_bank (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [50:0] prio_level,
	output logic      [16:0] prio_enabled
);
	localparam int N = prio_bank_pkg::REG_COUNT;
	localparam logic [4:0] ADDRS [N] = '{prio_bank_pkg::CTRL11_ADDR,
		prio_bank_pkg::CTRL12_ADDR, prio_bank_pkg::CTRL13_ADDR,
		prio_bank_pkg::CTRL14_ADDR, prio_bank_pkg::CTRL15_ADDR,
		prio_bank_pkg::CTRL16_ADDR};
	localparam logic [15:0] MASKS [N] = '{prio_bank_pkg::CTRL11_MASK,
		prio_bank_pkg::CTRL12_MASK, prio_bank_pkg::CTRL13_MASK,
		prio_bank_pkg::CTRL14_MASK, prio_bank_pkg::CTRL15_MASK,
		prio_bank_pkg::CTRL16_MASK};

	// Write side: address and data latched in either order
	logic        aw_held_reg;
	logic [4:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [15:0] w_data_reg;
	logic [1:0]  w_strb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        do_write;
	logic        awready_int;
	logic        wready_int;
	logic [N-1:0] wr_sel;
	logic [N-1:0] rd_sel;
	logic [15:0] words [N];
	logic [15:0] rd_word;
	logic        wr_hit;
	logic        rd_hit;

	// Read side
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        arready_int;
	// Ready flags are flops fed from the next state of the holding flags
	logic        awready_reg;
	logic        wready_reg;
	logic        arready_reg;
	logic        awready_next;
	logic        wready_next;
	logic        arready_next;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        aw_held_next;
	logic        w_held_next;
	logic        bvalid_next;
	logic        rvalid_next;

	assign awready_int = awready_reg;
	assign wready_int  = wready_reg;
	assign do_write    = aw_held_reg && w_held_reg && !bvalid_reg;
	assign arready_int = arready_reg;
	assign aw_take     = s_axi_awvalid && awready_int;
	assign w_take      = s_axi_wvalid && wready_int;
	assign ar_take     = s_axi_arvalid && arready_int;

	// Next states copy the holding flops so ready is known a cycle early
	assign aw_held_next = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_held_reg);
	assign w_held_next  = w_take ? 1'b1 : (do_write ? 1'b0 : w_held_reg);
	assign bvalid_next  = do_write ? 1'b1
		: (s_axi_bready ? 1'b0 : bvalid_reg);
	assign rvalid_next  = ar_take ? 1'b1
		: (s_axi_rready ? 1'b0 : rvalid_reg);
	assign awready_next = !aw_held_next && !bvalid_next;
	assign wready_next  = !w_held_next && !bvalid_next;
	assign arready_next = !rvalid_next;
	assign wr_hit      = |wr_sel;
	assign rd_hit      = |rd_sel;

	assign s_axi_awready = awready_int;
	assign s_axi_wready  = wready_int;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_int;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_word
			assign wr_sel[g] = aw_addr_reg == ADDRS[g];
			assign rd_sel[g] = s_axi_araddr == ADDRS[g];
			prio_word_reg #(
				.MASK (MASKS[g])
			) u_word (
				.clk     (clk),
				.resetn  (resetn),
				.wr_en   (do_write && wr_sel[g]),
				.wr_data (w_data_reg),
				.wr_strb (w_strb_reg),
				.value   (words[g])
			);
		end
	endgenerate

	always_comb begin
		rd_word = 16'h0000;
		for (int i = 0; i < N; i++)
			if (rd_sel[i])
				rd_word = words[i];
	end

	// Field order: lowest index is word 11 bits 14:12
	logic [2:0] codes [prio_bank_pkg::FIELD_COUNT];
	assign codes[0]  = words[0][14:12]; // timer6_prio
	assign codes[1]  = words[0][10:8];  // dma_ch4_done_prio
	assign codes[2]  = words[0][2:0];   // compare8_prio
	assign codes[3]  = words[1][14:12]; // timer8_prio
	assign codes[4]  = words[1][10:8];  // i2c_second_master_prio
	assign codes[5]  = words[1][6:4];   // i2c_second_slave_prio
	assign codes[6]  = words[1][2:0];   // timer7_prio
	assign codes[7]  = words[2][14:12]; // can_second_rx_ready_prio
	assign codes[8]  = words[2][10:8];  // ext_irq4_prio
	assign codes[9]  = words[2][6:4];   // ext_irq3_prio
	assign codes[10] = words[2][2:0];   // timer9_prio
	assign codes[11] = words[3][14:12]; // codec_if_error_prio
	assign codes[12] = words[3][2:0];   // can_second_event_prio
	assign codes[13] = words[4][6:4];   // dma_ch5_done_prio
	assign codes[14] = words[4][2:0];   // codec_if_event_prio
	assign codes[15] = words[5][10:8];  // uart_second_error_prio
	assign codes[16] = words[5][6:4];   // uart_first_error_prio

	logic [50:0] level_next;
	logic [16:0] enabled_next;
	logic [50:0] level_reg;
	logic [16:0] enabled_reg;

	generate
		for (g = 0; g < prio_bank_pkg::FIELD_COUNT; g++) begin : gen_dec
			prio_level_decode u_dec (
				.code    (codes[g]),
				.level   (level_next[3*g +: 3]),
				.enabled (enabled_next[g])
			);
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			level_reg   <= {17{3'h4}};
			enabled_reg <= 17'h1FFFF;
		end else begin
			level_reg   <= level_next;
			enabled_reg <= enabled_next;
		end
	end
	assign prio_level   = level_reg;
	assign prio_enabled = enabled_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			arready_reg <= 1'b1;
		end else begin
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			arready_reg <= arready_next;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 5'h00;
		end else if (s_axi_awvalid && awready_int) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (do_write)
			aw_held_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 16'h0000;
			w_strb_reg <= 2'h0;
		end else if (s_axi_wvalid && wready_int) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata[15:0];
			w_strb_reg <= s_axi_wstrb[1:0];
		end else if (do_write)
			w_held_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= prio_bank_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_hit ? prio_bank_pkg::RESP_OKAY
				: prio_bank_pkg::RESP_SLVERR;
		end else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= prio_bank_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_int) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= {16'h0000, rd_word};
			rresp_reg  <= rd_hit ? prio_bank_pkg::RESP_OKAY
				: prio_bank_pkg::RESP_SLVERR;
		end else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	highest_level_a: assert property (@(posedge clk) disable iff (!resetn)
		codes[0] == prio_bank_pkg::PRIO_HIGHEST |=>
		prio_level[2:0] == 3'h7 && prio_enabled[0])
		else $error("code 111 not level seven");
	lowest_level_a: assert property (@(posedge clk) disable iff (!resetn)
		codes[16] == prio_bank_pkg::PRIO_LOWEST |=>
		prio_level[50:48] == 3'h1 && prio_enabled[16])
		else $error("code 001 not level one");
	source_off_a: assert property (@(posedge clk) disable iff (!resetn)
		codes[5] == prio_bank_pkg::PRIO_OFF |=> !prio_enabled[5])
		else $error("code 000 left source enabled");
	read_resp_a: assert property (@(posedge clk) disable iff (!resetn)
		s_axi_arvalid && arready_int |=> s_axi_rvalid
		&& s_axi_rdata[31:16] == 16'h0000)
		else $error("read answer late or upper bits set");
	write_resp_a: assert property (@(posedge clk) disable iff (!resetn)
		do_write |=> s_axi_bvalid)
		else $error("write response missing");
	mask_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		(words[0] & ~prio_bank_pkg::CTRL11_MASK) == 16'h0000
		&& (words[5] & ~prio_bank_pkg::CTRL16_MASK) == 16'h0000)
		else $error("unused bits stored a write");
	order_up_a: assert property (@(posedge clk) disable iff (!resetn)
		codes[3] > codes[4] |=> prio_level[11:9] > prio_level[14:12])
		else $error("larger code not higher level");
	reset_four_a: assert property (@(posedge clk)
		$rose(resetn) |-> codes[7] == 3'h4 && codes[13] == 3'h4)
		else $error("field not level four at reset");

	// Handshake and refusal checks
	ready_track_a: assert property (@(posedge clk) disable iff (!resetn)
		s_axi_awready == (!aw_held_reg && !s_axi_bvalid)
		&& s_axi_wready == (!w_held_reg && !s_axi_bvalid)
		&& s_axi_arready == !s_axi_rvalid)
		else $error("ready flag out of step with state");
	bresp_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped early");
	wr_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
		do_write && !wr_hit
		|=> s_axi_bresp == prio_bank_pkg::RESP_SLVERR)
		else $error("unmapped write not refused");
	rd_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
		ar_take && !rd_hit |=> s_axi_rdata == 32'h00000000
		&& s_axi_rresp == prio_bank_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	single_write_a: assert property (@(posedge clk) disable iff (!resetn)
		do_write |=> !do_write)
		else $error("one write stored twice");
	reset_out_a: assert property (@(posedge clk)
		$rose(resetn) |-> prio_level == {17{3'h4}}
		&& prio_enabled == 17'h1FFFF)
		else $error("outputs not at level four after reset");
endmodule : interrupt_priority_bank

/* File: testbench/test_interrupt_priority_bank.sv */
`timescale 1ns/100ps
module test_interrupt_priority_bank;
	localparam logic [15:0] MK [6] = '{prio_bank_pkg::CTRL11_MASK,
		prio_bank_pkg::CTRL12_MASK, prio_bank_pkg::CTRL13_MASK,
		prio_bank_pkg::CTRL14_MASK, prio_bank_pkg::CTRL15_MASK,
		prio_bank_pkg::CTRL16_MASK};
	localparam logic [1:0]  OK = prio_bank_pkg::RESP_OKAY;
	localparam logic [1:0]  SE = prio_bank_pkg::RESP_SLVERR;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  aw_addr = '0;
	logic [4:0]  ar_addr = '0;
	logic [31:0] w_data = '0;
	logic [3:0]  w_strb = '0;
	logic        aw_valid = 1'b0;
	logic        w_valid = 1'b0;
	logic        b_ready = 1'b0;
	logic        ar_valid = 1'b0;
	logic        r_ready = 1'b0;
	logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [1:0]  b_resp, r_resp;
	logic [31:0] r_data;
	logic [50:0] prio_level;
	logic [16:0] prio_enabled;
	logic [15:0] m [6];
	int          fail_count = 0;
	int          num_checks = 0;
	int          seed = 91;
	int          r;

	interrupt_priority_bank interrupt_priority_bank_inst (
		.clk(clk), .resetn(resetn),
		.s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
		.s_axi_awready(aw_ready), .s_axi_wdata(w_data),
		.s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
		.s_axi_wready(w_ready), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
		.s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
		.s_axi_arready(ar_ready), .s_axi_rdata(r_data),
		.s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
		.s_axi_rready(r_ready), .prio_level(prio_level),
		.prio_enabled(prio_enabled));

	always #5 clk = ~clk;

	task check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task results;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// Field order per source index, 0 to 16
	function automatic logic [50:0] exp_level();
		logic [2:0]  f [17];
		logic [50:0] e;
		f = '{m[0][14:12], m[0][10:8], m[0][2:0], m[1][14:12], m[1][10:8],
			m[1][6:4], m[1][2:0], m[2][14:12], m[2][10:8], m[2][6:4],
			m[2][2:0], m[3][14:12], m[3][2:0], m[4][6:4], m[4][2:0],
			m[5][10:8], m[5][6:4]};
		for (int i = 0; i < 17; i++)
			e[3*i +: 3] = f[i];
		return e;
	endfunction : exp_level

	task do_reset;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		check(prio_level, {17{3'h4}});
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			m[i] = prio_bank_pkg::PRIO_RESET & MK[i];
	endtask : do_reset

	task automatic wr(input logic [4:0] a, input logic [15:0] d,
			input logic [1:0] st, input logic [1:0] er);
		logic        pa, pw, ta, tw, tb;
		logic [1:0]  rsp;
		logic [15:0] bm;
		int          n;
		@(posedge clk);
		pa = 1'b1;
		pw = 1'b1;
		tb = 1'b0;
		n = 0;
		aw_addr <= a;
		w_data <= {16'($random(seed)), d};
		w_strb <= {2'($random(seed)), st};
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		while (!tb && n < 40) begin
			@(negedge clk);
			n++;
			ta = pa && aw_ready;
			tw = pw && w_ready;
			tb = b_valid && b_ready;
			rsp = b_resp;
			@(posedge clk);
			// Response ready rises after a random wait, then holds
			if (!tb)
				b_ready <= b_ready | 1'($random(seed));
			if (ta) begin
				aw_valid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				w_valid <= 1'b0;
				pw = 1'b0;
			end
		end
		b_ready <= 1'b0;
		check(tb, 1'b1);
		check(rsp, er);
		bm = {{8{st[1]}}, {8{st[0]}}};
		if (er === OK)
			m[a[4:2]] = (m[a[4:2]] & ~bm) | (d & MK[a[4:2]] & bm);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] ed,
			input logic [1:0] er);
		logic        pa, ta, tr;
		logic [31:0] d;
		logic [1:0]  rsp;
		int          n;
		@(posedge clk);
		pa = 1'b1;
		tr = 1'b0;
		n = 0;
		ar_addr <= a;
		ar_valid <= 1'b1;
		while (!tr && n < 40) begin
			@(negedge clk);
			n++;
			ta = pa && ar_ready;
			tr = r_valid && r_ready;
			d = r_data;
			rsp = r_resp;
			@(posedge clk);
			if (!tr)
				r_ready <= r_ready | 1'($random(seed));
			if (ta) begin
				ar_valid <= 1'b0;
				pa = 1'b0;
			end
		end
		r_ready <= 1'b0;
		check(tr, 1'b1);
		check(d, ed);
		check(rsp, er);
	endtask : rd

	task rd_all;
		for (int i = 0; i < 6; i++)
			rd(5'(4*i), {16'h0000, m[i]}, OK);
	endtask : rd_all

	task lv_check;
		logic [50:0] e;
		logic [16:0] en;
		repeat (2) @(posedge clk);
		@(negedge clk);
		e = exp_level();
		for (int i = 0; i < 17; i++)
			en[i] = |e[3*i +: 3];
		check(prio_level, e);
		check(prio_enabled, en);
	endtask : lv_check

	initial begin
		do_reset;
		rd_all;
		lv_check;
		$display("test reset done");
		for (int k = 0; k < 36; k++) begin
			r = (k < 6) ? 32'hFFFF : $random(seed);
			wr(5'(4*(k%6)), r[15:0], 2'b11, OK);
			rd(5'(4*(k%6)), {16'h0000, m[k%6]}, OK);
		end
		rd_all;
		lv_check;
		$display("test random done");
		for (int c = 0; c < 8; c++) begin
			wr(prio_bank_pkg::CTRL12_ADDR, {4{1'b0, 3'(c)}}, 2'b11, OK);
			lv_check;
		end
		$display("test codes done");
		wr(prio_bank_pkg::CTRL13_ADDR, 16'h1234, 2'b01, OK);
		wr(prio_bank_pkg::CTRL16_ADDR, 16'hFFFF, 2'b10, OK);
		rd_all;
		$display("test strobe done");
		wr(5'h18, 16'h7777, 2'b11, SE);
		rd(5'h1C, 32'h00000000, SE);
		rd_all;
		$display("test unmapped done");
		do_reset;
		rd_all;
		lv_check;
		$display("test rereset done");
		results;
	end

	initial begin
		#200000;
		fail_count++;
		results;
	end
endmodule : test_interrupt_priority_bank
